// ===== include/cch_regs.svh
// register map, field positions, codes and timing counts of the mailbox
// assumes an 8-bit byte-select register port and a 20 MHz reference clock
`ifndef CCH_REGS_SVH
`define CCH_REGS_SVH

// ==========================================
// byte selects of the host register window
`define CCH_SEL_CTL0 3'h0
`define CCH_SEL_MCTL 3'h1
`define CCH_SEL_CMD 3'h2
`define CCH_SEL_TRIB 3'h3
`define CCH_SEL_DLO 3'h4
`define CCH_SEL_DHI 3'h5
`define CCH_SEL_KEY 3'h6
`define CCH_SEL_DTOP 3'h7

// ==========================================
// field positions
`define CCH_B_IEN_IN 0
`define CCH_B_IEN_OUT 4
`define CCH_B_RQI 7
`define CCH_B_MCLR 6
`define CCH_B_RUN 7
`define CCH_B_EXT22 3
`define CCH_B_GRANT 4
`define CCH_B_RDO 7
`define CCH_CTL0_MASK 8'h91
`define CCH_CTL0_RST 8'h00

// ==========================================
// command, request key and response codes
`define CCH_CMD_CONTROL 3'h1
`define CCH_RQK_MODEM 5'h01
`define CCH_RQK_HALT 5'h02
`define CCH_RSP_INFO 3'h2
`define CCH_RSP_BUFRET 3'h4
// return keys, octal 10 and octal 20
`define CCH_KEY_MODEM 5'h08
`define CCH_KEY_DONE 5'h10

// ==========================================
// start-up timing
`define CCH_CLK_MHZ 20
`define CCH_START_NS 1000
`define CCH_START_CYC ((`CCH_START_NS * `CCH_CLK_MHZ + 999) / 1000)

`endif

// ===== include/cch_pkg.sv
// types shared by the mailbox modules
// assumes nothing beyond a SystemVerilog compiler
package cch_pkg;
    // ==========================================
    // handshake sequencer states
    typedef enum logic [2:0] {
        ST_START = 3'h0,
        ST_IDLE = 3'h1,
        ST_GRANT = 3'h2,
        ST_EXEC = 3'h3,
        ST_SCAN = 3'h4,
        ST_CHECK = 3'h5,
        ST_POST = 3'h6
    } cch_state_t;

    // one buffer ownership entry
    typedef struct packed {
        logic valid;
        logic common;
        logic [7:0] trib;
    } cch_entry_t;
endpackage

// ===== include/cch_irq_if.sv
// carrier between the sequencer and the interrupt stage
// assumes both ends share the reference clock
`timescale 1ns/1ps
interface cch_irq_if;
    logic ien_in; // grant interrupt enable
    logic ien_out; // response interrupt enable
    logic granted; // port held by host for a command
    logic response_ready; // response waiting in the port
    logic irq_in; // grant interrupt request
    logic irq_out; // response interrupt request
    modport ctl (output ien_in, ien_out, granted, response_ready, input irq_in, irq_out);
    modport irq (input ien_in, ien_out, granted, response_ready, output irq_in, irq_out);
endinterface

// ===== verilog/cch_buf_mem.sv
// buffer ownership table, one write port and one registered read port
// assumes the caller never writes and reads the same entry in one cycle
`timescale 1ns/1ps
module cch_buf_mem #(
    parameter int DEPTH = 16
) (
    // clock and clear
    input wire logic i_clk,
    input wire logic i_clr,
    // write side
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire cch_pkg::cch_entry_t i_wdata,
    // read side
    input wire logic i_re,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output cch_pkg::cch_entry_t o_rdata
);
    // ==========================================
    // storage; valid bits are flops so a clear empties the table at once
    logic [8:0] mem_r [DEPTH];
    logic [DEPTH-1:0] valid_r;

    // payload array, no reset needed since valid gates it
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= {i_wdata.common, i_wdata.trib};
        end
    end

    // valid vector
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            valid_r <= '0;
        end else if (i_we) begin
            valid_r[i_waddr] <= i_wdata.valid;
        end
    end

    // registered read
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            o_rdata <= '0;
        end else if (i_re) begin
            o_rdata <= {valid_r[i_raddr], mem_r[i_raddr]};
        end
    end
endmodule

// ===== verilog/cch_irq_gen.sv
// interrupt request stage for the grant and response vectors
// assumes a synchronous active-low reset on the reference clock
`timescale 1ns/1ps
module cch_irq_gen (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // sequencer side
    cch_irq_if.irq bus
);
    // ==========================================
    // level requests, held while cause and enable both stand
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            bus.irq_in <= 1'b0;
            bus.irq_out <= 1'b0;
        end else begin
            bus.irq_in <= bus.ien_in & bus.granted; // RL9
            bus.irq_out <= bus.ien_out & bus.response_ready; // RL9
        end
    end
endmodule

// ===== verilog/cch_mailbox.sv
// command and response mailbox seen by the host through byte registers
// assumes the host keeps its side of the port discipline
// Summary of operation
// [RL1] modem status key puts status in data bytes
// [RL2] post completion key after all buffers returned
// [RL3] start message returns tributary private buffers
// [RL4] maintenance message returns tributary private buffers
// [RL5] halt key on tributary returns its buffers
// [RL6] global halt key returns unused common buffers
// [RL7] completion response carries zero data bytes
// [RL8] two interrupt enables at bits zero, four
// [RL9] interrupt on grant and on posted response
// [RL10] master clear first, wait for run
// [RL11] host requests port with enable together
// [RL12] grant bit four of command byte
// [RL13] bit three selects extended address format
// [RL14] host loads data words then command
// [RL15] single command: drop request before writing
// [RL16] held request regrants after next response
// [RL17] host should keep both interrupts enabled
// [RL18] load data, then set ready and code
// [RL19] host clears ready, port returns to device
// [RL20] post only while grant bit clear
// [RL21] command write consumes port, grant clears
// [RL22] master clear zeroes enables, request, grant, ready
`timescale 1ns/1ps
`include "cch_regs.svh"
module cch_mailbox #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // host register port
    input wire logic [2:0] i_csr_sel,
    input wire logic i_csr_wr,
    input wire logic i_csr_rd,
    input wire logic [7:0] i_csr_wdata,
    output logic [7:0] o_csr_rdata,
    // link events and modem
    input wire logic i_evt_flush,
    input wire logic [7:0] i_evt_trib,
    input wire logic [15:0] i_modem_status,
    // buffer assignment
    input wire logic i_buf_wr,
    input wire logic [$clog2(DEPTH)-1:0] i_buf_idx,
    input wire logic i_buf_common,
    input wire logic [7:0] i_buf_trib,
    output logic o_buf_ready,
    // status and interrupts
    output logic o_run,
    output logic o_irq_in,
    output logic o_irq_out
);
    // ==========================================
    // parameters and checks
    localparam int IW = $clog2(DEPTH);
    localparam int START_CYC = `CCH_START_CYC;
    if (DEPTH < 2 || DEPTH > 256 || START_CYC > 256) begin : g_chk
        $error("cch_mailbox: DEPTH must be 2..256");
    end

    // ==========================================
    // state
    cch_pkg::cch_state_t state_r; // sequencer
    logic [7:0] cnt_r; // start-up counter
    logic run_r; // run indication
    logic [7:0] ctl0_r; // enables and request
    logic granted_r; // port granted to host
    logic rdo_r; // response ready
    logic [2:0] code_r; // command or response code
    logic ext22_r; // extended address format
    logic [7:0] trib_r; // tributary address byte
    logic [7:0] dlo_r; // data word a low
    logic [7:0] dhi_r; // data word a high
    logic [7:0] key_r; // data word b low, key field
    logic [7:0] dtop_r; // data word b high
    logic pend_r; // link event asks for buffer return
    logic [7:0] pend_trib_r; // its tributary
    logic [7:0] scan_trib_r; // tributary being flushed
    logic scan_common_r; // flushing the common pool
    logic [IW:0] idx_r; // scan index, one past the end means done
    logic back_r; // after the post, resume the scan
    logic ready_r; // assignment port open
    logic [7:0] rdata_r; // register read data

    // ==========================================
    // decode
    logic mclr_wr; // master clear request
    logic submit; // command written while granted
    logic is_ctl;
    logic is_halt;
    logic is_modem;
    logic scan_end;
    logic hit;
    cch_pkg::cch_entry_t ent;
    logic post_go;
    logic [2:0] post_type;
    logic [4:0] post_key;
    logic [15:0] post_data;
    logic [7:0] post_trib;

    assign mclr_wr = i_csr_wr && i_csr_sel == `CCH_SEL_MCTL && i_csr_wdata[`CCH_B_MCLR];
    assign submit = i_csr_wr && i_csr_sel == `CCH_SEL_CMD && granted_r; // RL21
    assign is_ctl = code_r == `CCH_CMD_CONTROL;
    assign is_halt = is_ctl && key_r[4:0] == `CCH_RQK_HALT;
    assign is_modem = is_ctl && key_r[4:0] == `CCH_RQK_MODEM;
    assign scan_end = idx_r == (IW+1)'(DEPTH);
    // common pool entries match a global flush, private ones their tributary
    assign hit = ent.valid && (scan_common_r ? ent.common :
                 (!ent.common && ent.trib == scan_trib_r));

    // ==========================================
    // response selection; only reachable states never hold a grant
    always_comb begin // RL20
        post_go = 1'b0;
        post_type = `CCH_RSP_INFO;
        post_key = 5'h00;
        post_data = 16'h0000;
        post_trib = scan_trib_r;
        if (state_r == cch_pkg::ST_EXEC && !is_halt && is_modem) begin
            post_go = 1'b1;
            post_key = `CCH_KEY_MODEM;
            post_data = i_modem_status; // RL1
            post_trib = trib_r;
        end else if (state_r == cch_pkg::ST_SCAN && scan_end) begin
            post_go = 1'b1; // RL2
            post_key = `CCH_KEY_DONE;
            post_data = 16'h0000; // RL7
        end else if (state_r == cch_pkg::ST_CHECK && hit) begin
            post_go = 1'b1;
            post_type = `CCH_RSP_BUFRET;
            post_data = 16'(idx_r);
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            state_r <= cch_pkg::ST_START;
            cnt_r <= 8'h00;
            run_r <= 1'b0;
        end else begin
            unique case (state_r)
                cch_pkg::ST_START: begin
                    // self test time before the host may talk to us
                    if (cnt_r == 8'(START_CYC - 1)) begin
                        run_r <= 1'b1; // RL10
                        state_r <= cch_pkg::ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                cch_pkg::ST_IDLE: begin
                    // buffer returns win over a new grant
                    if (pend_r) begin
                        state_r <= cch_pkg::ST_SCAN;
                    end else if (ctl0_r[`CCH_B_RQI] && !rdo_r) begin
                        state_r <= cch_pkg::ST_GRANT; // RL16
                    end
                end
                cch_pkg::ST_GRANT: begin
                    if (submit) begin
                        state_r <= cch_pkg::ST_EXEC;
                    end
                end
                cch_pkg::ST_EXEC: begin
                    if (is_halt) begin
                        state_r <= cch_pkg::ST_SCAN; // RL5 RL6
                    end else if (is_modem) begin
                        state_r <= cch_pkg::ST_POST;
                    end else begin
                        state_r <= cch_pkg::ST_IDLE;
                    end
                end
                cch_pkg::ST_SCAN: begin
                    state_r <= scan_end ? cch_pkg::ST_POST : cch_pkg::ST_CHECK;
                end
                cch_pkg::ST_CHECK: begin
                    state_r <= hit ? cch_pkg::ST_POST : cch_pkg::ST_SCAN;
                end
                cch_pkg::ST_POST: begin
                    // wait for the host to take the response
                    if (!rdo_r) begin
                        state_r <= back_r ? cch_pkg::ST_SCAN : cch_pkg::ST_IDLE; // RL19
                    end
                end
                default: begin
                    state_r <= cch_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // pending link flush; a new event in the taking cycle wins
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            pend_r <= 1'b0;
            pend_trib_r <= 8'h00;
        end else if (i_evt_flush && run_r) begin
            pend_r <= 1'b1; // RL3 RL4
            pend_trib_r <= i_evt_trib;
        end else if (state_r == cch_pkg::ST_IDLE) begin
            pend_r <= 1'b0;
        end
    end

    // ==========================================
    // scan control and assignment port gating
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            scan_trib_r <= 8'h00;
            scan_common_r <= 1'b0;
            idx_r <= '0;
            back_r <= 1'b0;
            ready_r <= 1'b0;
        end else if (state_r == cch_pkg::ST_IDLE && pend_r) begin
            scan_trib_r <= pend_trib_r; // RL3 RL4
            scan_common_r <= 1'b0;
            idx_r <= '0;
            back_r <= 1'b1;
            ready_r <= 1'b0;
        end else if (state_r == cch_pkg::ST_EXEC && is_halt) begin
            scan_trib_r <= trib_r;
            scan_common_r <= trib_r == 8'h00; // RL6
            idx_r <= '0;
            back_r <= 1'b1;
            ready_r <= 1'b0;
        end else if (state_r == cch_pkg::ST_CHECK) begin
            idx_r <= idx_r + (IW+1)'(1);
        end else if (state_r == cch_pkg::ST_SCAN && scan_end) begin
            back_r <= 1'b0;
            ready_r <= 1'b1;
        end else if (state_r == cch_pkg::ST_START || state_r == cch_pkg::ST_IDLE) begin
            ready_r <= !back_r;
        end
    end

    // ==========================================
    // first control byte
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            ctl0_r <= `CCH_CTL0_RST; // RL22
        end else if (i_csr_wr && i_csr_sel == `CCH_SEL_CTL0) begin
            ctl0_r <= i_csr_wdata & `CCH_CTL0_MASK; // RL8
        end
    end

    // ==========================================
    // command byte; a post wins over a host clear of ready
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            granted_r <= 1'b0; // RL22
            rdo_r <= 1'b0;
            code_r <= 3'h0;
            ext22_r <= 1'b0;
        end else begin
            if (state_r == cch_pkg::ST_IDLE && !pend_r && ctl0_r[`CCH_B_RQI] && !rdo_r) begin
                granted_r <= 1'b1; // RL12
            end else if (submit) begin
                granted_r <= 1'b0; // RL21
            end
            if (i_csr_wr && i_csr_sel == `CCH_SEL_CMD) begin
                code_r <= i_csr_wdata[2:0];
                ext22_r <= i_csr_wdata[`CCH_B_EXT22]; // RL13
                if (!i_csr_wdata[`CCH_B_RDO]) begin
                    rdo_r <= 1'b0; // RL19
                end
            end
            if (post_go) begin
                rdo_r <= 1'b1; // RL18
                code_r <= post_type;
            end
        end
    end

    // ==========================================
    // data port bytes; device loads them in the same edge as ready
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || mclr_wr) begin
            trib_r <= 8'h00;
            dlo_r <= 8'h00;
            dhi_r <= 8'h00;
            key_r <= 8'h00;
            dtop_r <= 8'h00;
        end else if (post_go) begin
            trib_r <= post_trib; // RL18
            dlo_r <= post_data[7:0];
            dhi_r <= post_data[15:8];
            key_r <= {3'h0, post_key};
            dtop_r <= 8'h00;
        end else if (i_csr_wr) begin
            if (i_csr_sel == `CCH_SEL_TRIB) trib_r <= i_csr_wdata;
            if (i_csr_sel == `CCH_SEL_DLO) dlo_r <= i_csr_wdata;
            if (i_csr_sel == `CCH_SEL_DHI) dhi_r <= i_csr_wdata;
            if (i_csr_sel == `CCH_SEL_KEY) key_r <= i_csr_wdata;
            if (i_csr_sel == `CCH_SEL_DTOP) dtop_r <= i_csr_wdata;
        end
    end

    // ==========================================
    // register read, one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdata_r <= 8'h00;
        end else if (i_csr_rd) begin
            unique case (i_csr_sel)
                `CCH_SEL_CTL0: rdata_r <= ctl0_r;
                `CCH_SEL_MCTL: rdata_r <= {run_r, state_r == cch_pkg::ST_START, 6'h00};
                `CCH_SEL_CMD: rdata_r <= {rdo_r, 2'h0, granted_r, ext22_r, code_r};
                `CCH_SEL_TRIB: rdata_r <= trib_r;
                `CCH_SEL_DLO: rdata_r <= dlo_r;
                `CCH_SEL_DHI: rdata_r <= dhi_r;
                `CCH_SEL_KEY: rdata_r <= key_r;
                `CCH_SEL_DTOP: rdata_r <= dtop_r;
            endcase
        end
    end

    // ==========================================
    // ownership table; scan clears win the port because ready is low then
    cch_buf_mem #(.DEPTH(DEPTH)) u_mem (
        .i_clk(i_ref_clk),
        .i_clr(!i_rst_n || mclr_wr),
        .i_we((state_r == cch_pkg::ST_CHECK && hit) || (i_buf_wr && ready_r)),
        .i_waddr(state_r == cch_pkg::ST_CHECK ? idx_r[IW-1:0] : i_buf_idx),
        .i_wdata(state_r == cch_pkg::ST_CHECK ? '0 : {1'b1, i_buf_common, i_buf_trib}),
        .i_re(state_r == cch_pkg::ST_SCAN),
        .i_raddr(idx_r[IW-1:0]),
        .o_rdata(ent)
    );

    // ==========================================
    // interrupts
    cch_irq_if irq_bus ();
    assign irq_bus.ien_in = ctl0_r[`CCH_B_IEN_IN];
    assign irq_bus.ien_out = ctl0_r[`CCH_B_IEN_OUT];
    assign irq_bus.granted = granted_r;
    assign irq_bus.response_ready = rdo_r;
    cch_irq_gen u_irq (
        .i_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .bus(irq_bus)
    );

    // outputs, each a flop
    assign o_csr_rdata = rdata_r;
    assign o_buf_ready = ready_r;
    assign o_run = run_r;
    assign o_irq_in = irq_bus.irq_in;
    assign o_irq_out = irq_bus.irq_out;

    // ==========================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_grant_on_req: assert property ($rose(granted_r) |-> $past(ctl0_r[7])) // RL12
        else $error("grant without request");
    a_post_free_port: assert property ($rose(rdo_r) |-> !granted_r) // RL20
        else $error("response posted while granted");
    a_submit_drops: assert property (submit && !post_go |=> !granted_r) // RL21
        else $error("grant stays after command");
    a_done_zero: assert property ($rose(rdo_r) && key_r[4:0] == 5'h10 |-> // RL7
        dlo_r == 8'h00 && dhi_r == 8'h00)
        else $error("completion data not zero");
    a_modem_data: assert property (state_r == cch_pkg::ST_EXEC && is_modem && !is_halt |=> // RL1
        rdo_r && key_r[4:0] == 5'h08 && {dhi_r, dlo_r} == $past(i_modem_status))
        else $error("modem status not posted");
    a_mclr_clears: assert property (mclr_wr |=> !granted_r && !rdo_r && ctl0_r == 8'h00 // RL22
        ##0 !run_r [*8])
        else $error("master clear left state");
    a_irq_in: assert property (granted_r && ctl0_r[0] |=> o_irq_in) // RL9
        else $error("grant interrupt missing");
    a_irq_out: assert property (!(rdo_r && ctl0_r[4]) |=> !o_irq_out) // RL9
        else $error("spurious response interrupt");
    a_ien_write: assert property (i_csr_wr && i_csr_sel == 3'h0 |=> // RL8
        ctl0_r[0] == $past(i_csr_wdata[0]) && ctl0_r[4] == $past(i_csr_wdata[4]))
        else $error("enable bits not written");
    a_halt_scan: assert property (state_r == cch_pkg::ST_EXEC && is_halt |=> // RL5
        state_r == cch_pkg::ST_SCAN && scan_trib_r == $past(trib_r))
        else $error("halt did not start return");
    a_done_post: assert property (state_r == cch_pkg::ST_SCAN && scan_end |=> // RL2
        rdo_r && code_r == 3'h2 && key_r[4:0] == 5'h10)
        else $error("completion not posted");
    a_ext22: assert property (i_csr_wr && i_csr_sel == 3'h2 |=> // RL13
        ext22_r == $past(i_csr_wdata[3]))
        else $error("format bit not kept");

    c_grant: cover property ($rose(granted_r) ##[1:50] submit);
    c_flush_done: cover property (state_r == cch_pkg::ST_CHECK && hit ##[1:100] scan_end);
    c_modem: cover property (state_r == cch_pkg::ST_EXEC && is_modem);
endmodule

// ===== dv/cch_host_model.sv
// host program model: drives the byte register window of the mailbox
// assumes the bench calls its tasks from one process and the clock runs free
`timescale 1ns/1ps
module cch_host_model (
    // clock
    input wire logic i_clk,
    // register port
    output logic [2:0] o_sel,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    // interrupts
    input wire logic i_irq_in,
    input wire logic i_irq_out
);
    // ==========================================
    // bus primitives
    initial begin
        o_sel = 3'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // one byte write; data inverted after the strobe so stale data never looks valid
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(negedge i_clk);
        o_sel = sel;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    // one byte read, data taken a cycle after the read edge
    task automatic rd(input logic [2:0] sel, output logic [7:0] d);
        @(negedge i_clk);
        o_sel = sel;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        d = i_rdata;
    endtask
    // ==========================================
    // handshake procedures
    // poll for the grant, bounded; g returns the grant interrupt level sampled once polling stops
    task automatic poll_grant(output logic g);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 60 && b[4] !== 1'b1; i++) rd(3'h2, b);
        g = i_irq_in;
    endtask
    // claim port with enables in the same write, load bytes, then the code
    task automatic cmd(input logic [7:0] trib, input logic [7:0] key, input logic hold,
                       input logic [7:0] code, output logic g);
        wr(3'h0, 8'h91);
        poll_grant(g);
        wr(3'h3, trib);
        wr(3'h6, key);
        wr(3'h7, 8'h00);
        // single command drops the request first; a series keeps it
        if (!hold) wr(3'h0, 8'h11);
        wr(3'h2, code);
    endtask
    // wait for the response interrupt, copy the port, then hand it back
    task automatic get_rsp(output logic [39:0] r);
        for (int i = 0; i < 200 && i_irq_out !== 1'b1; i++) @(negedge i_clk);
        rd(3'h2, r[39:32]);
        rd(3'h3, r[31:24]);
        rd(3'h5, r[23:16]);
        rd(3'h4, r[15:8]);
        rd(3'h6, r[7:0]);
        wr(3'h2, 8'h00);
        // the interrupt falls a cycle after the clear; a stale level would fake the next post
        @(negedge i_clk);
    endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the command and response mailbox
// assumes the host model drives the register port; link and buffer pins driven here
`timescale 1ns/1ps
`include "cch_regs.svh"
module tb_top;
    // ==========================================
    // clock, reset and pins
    logic clk = 1'b0; // 20 MHz reference
    logic rst_n = 1'b0;
    logic [2:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic evt = 1'b0;
    logic [7:0] evt_trib = 8'h00;
    logic [15:0] modem = 16'hA5C3;
    logic bwr = 1'b0;
    logic [3:0] bidx = 4'h0;
    logic bcom = 1'b0;
    logic [7:0] btrib = 8'h00;
    logic bready;
    logic run;
    logic irq_in;
    logic irq_out;
    logic [7:0] b;
    logic g;
    logic [15:0] rows [4] = '{16'hFF91, 16'h1111, 16'h8080, 16'h0000}; // written, read back
    int miscompares = 0;
    int compares = 0;
    always #25 clk = ~clk;
    cch_mailbox #(.DEPTH(16)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_csr_sel(sel),
        .i_csr_wr(wr), .i_csr_rd(rd), .i_csr_wdata(wdata), .o_csr_rdata(rdata),
        .i_evt_flush(evt), .i_evt_trib(evt_trib), .i_modem_status(modem), .i_buf_wr(bwr),
        .i_buf_idx(bidx), .i_buf_common(bcom), .i_buf_trib(btrib), .o_buf_ready(bready),
        .o_run(run), .o_irq_in(irq_in), .o_irq_out(irq_out));
    cch_host_model host_u (.i_clk(clk), .o_sel(sel), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .i_rdata(rdata), .i_irq_in(irq_in), .i_irq_out(irq_out));
    // ==========================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // master clear, then wait for run under a bound
    task automatic mclr();
        host_u.wr(3'h1, 8'h40);
        host_u.rd(3'h0, b);
        check({8'h00, b}, 16'h0000);
        for (int i = 0; i < 40 && run !== 1'b1; i++) @(negedge clk);
        check({15'h0, run}, 16'h0001);
    endtask
    // assign one buffer entry through the ownership port
    task automatic abuf(input logic [3:0] idx, input logic com, input logic [7:0] trib);
        @(negedge clk);
        bidx = idx;
        bcom = com;
        btrib = trib;
        bwr = 1'b1;
        check({15'h0, bready}, 16'h0001);
        @(negedge clk);
        bwr = 1'b0;
    endtask
    // expected response: {command byte, tributary, data high, data low, key}
    task automatic ersp(input logic [39:0] e);
        logic [39:0] r;
        host_u.get_rsp(r);
        check(r[39:24], e[39:24]);
        check(r[23:8], e[23:8]);
        check({8'h00, r[7:0]}, {8'h00, e[7:0]});
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        mclr();
        foreach (rows[i]) begin
            host_u.wr(3'h0, rows[i][15:8]);
            host_u.rd(3'h0, b);
            check({8'h00, b}, {8'h00, rows[i][7:0]});
        end
        abuf(4'h2, 1'b0, 8'h05);
        abuf(4'h3, 1'b1, 8'h00);
        abuf(4'h7, 1'b0, 8'h05);
        abuf(4'h4, 1'b0, 8'h09);
        host_u.cmd(8'h05, {3'h0, `CCH_RQK_MODEM}, 1'b0, 8'h01, g);
        check({15'h0, g}, 16'h0001);
        ersp({8'h82, 8'h05, 16'hA5C3, 3'h0, `CCH_KEY_MODEM});
        repeat (2) @(negedge clk);
        check({15'h0, irq_out}, 16'h0000);
        host_u.cmd(8'h05, {3'h0, `CCH_RQK_HALT}, 1'b0, 8'h01, g);
        ersp({8'h84, 8'h05, 16'h0002, 8'h00});
        check({15'h0, bready}, 16'h0000);
        ersp({8'h84, 8'h05, 16'h0007, 8'h00});
        ersp({8'h82, 8'h05, 16'h0000, 3'h0, `CCH_KEY_DONE});
        host_u.cmd(8'h00, {3'h0, `CCH_RQK_HALT}, 1'b0, 8'h01, g);
        ersp({8'h84, 8'h00, 16'h0003, 8'h00});
        ersp({8'h82, 8'h00, 16'h0000, 3'h0, `CCH_KEY_DONE});
        @(negedge clk);
        evt = 1'b1;
        evt_trib = 8'h09;
        @(negedge clk);
        evt = 1'b0;
        ersp({8'h84, 8'h09, 16'h0004, 8'h00});
        ersp({8'h82, 8'h09, 16'h0000, 3'h0, `CCH_KEY_DONE});
        // held request: port comes back after the response is cleared
        host_u.cmd(8'h05, {3'h0, `CCH_RQK_MODEM}, 1'b1, 8'h01, g);
        ersp({8'h82, 8'h05, 16'hA5C3, 3'h0, `CCH_KEY_MODEM});
        host_u.poll_grant(g);
        check({15'h0, g}, 16'h0001);
        host_u.wr(3'h0, 8'h11);
        host_u.wr(3'h2, 8'h00);
        host_u.rd(3'h2, b);
        check({8'h00, b}, 16'h0000);
        host_u.wr(3'h2, 8'h08);
        host_u.rd(3'h2, b);
        check({8'h00, b}, 16'h0008);
        mclr();
        test_done();
    end
    // watchdog sized well past the longest expected run
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule
